//--- ppg_pkg.sv
// Purpose: constants, register map and mode codes of the three-channel pulse generator
// Assumes: 25 MHz system clock, 32-bit AHB-Lite register access
// Notes:   one register word per aligned address, 0x40 bytes per channel
`default_nettype none

package ppg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned CYC_TICK = CLK_HZ / 1000 * TICK_MS;
  localparam int NCH = 3;
  localparam int NPAIR = 3;

  // pulse widths in 10 ms ticks
  localparam logic [9:0] W_MIN = 10'h001;
  localparam logic [9:0] W_MAX = 10'h3e8;
  localparam logic [9:0] W_DEF = 10'h014;
  localparam logic [9:0] W_ZERO = 10'h00a;
  localparam logic [9:0] W_ONE = 10'h014;

  // synthesizer: 32-bit phase accumulator, phase offset only below 10 kHz
  localparam longint unsigned SYN_PHASE_HZ = 10_000;
  localparam logic [31:0] SYN_PHASE_LIM = 32'((SYN_PHASE_HZ << 32) / longint'(CLK_HZ));

  // time of day
  localparam logic [16:0] SEC_PER_HOUR = 17'h00e10;
  localparam logic [16:0] SEC_PER_MIN = 17'h0003c;
  localparam logic [5:0] SEC_LAST = 6'h3b;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [1:0] STATUS_SLOT = 2'h3;
  localparam logic [5:0] OFF_STATUS = 6'h00;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_WIDTH = 6'h04;
  localparam logic [5:0] OFF_TIME = 6'h08;
  localparam logic [5:0] OFF_ON0 = 6'h0c;
  localparam logic [5:0] OFF_OFF0 = 6'h10;
  localparam logic [5:0] PAIR_STRIDE = 6'h08;
  localparam logic [5:0] OFF_FREQ = 6'h24;
  localparam logic [5:0] OFF_PHASE = 6'h28;
  localparam int CTRL_INV = 4;
  localparam int CTRL_IMM = 5;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  typedef enum logic [3:0] {
    MODE_IDLE, MODE_TIMER, MODE_SHOT, MODE_CYCLIC, MODE_PER_SEC, MODE_PER_MIN,
    MODE_PER_HOUR, MODE_SYNTH, MODE_TCODE, MODE_POS_OK, MODE_TIME_SYNC,
    MODE_ALL_SYNC, MODE_TELEGRAM
  } ppg_mode_t;

  // values after reset
  localparam logic [3:0] RST_MODE [NCH] = '{4'(MODE_PER_SEC), 4'(MODE_PER_MIN),
                                            4'(MODE_TELEGRAM)};
  localparam logic [16:0] RST_TIME = 17'h00001;

endpackage : ppg_pkg

`default_nettype wire

//--- ppg_pulse_gen.sv
// Purpose: three programmable pulse output channels locked to the one-second timing frame
// Assumes: sec_tick and time/date/status inputs come from logic on clk
// Notes:   registers over AHB-Lite, writes take one wait state, reads none
//
// Overview of operation
// - synthesizer mode outputs 1/8 Hz to 10 MHz, relocked to the second frame.
// - below 10 kHz the synthesizer phase is shiftable by up to a full period.
// - each channel keeps its own mode and parameters.
// - timer mode switches on and off at three programmable daily pairs.
// - cyclic pulses fall on integer multiples of the cycle counted from midnight.
// - single shot gives one programmable-width pulse per day at programmed time.
// - per-second, per-minute, per-hour modes pulse on each such change.
// - status modes follow position solved or timing synchronized.
// - combined status is the AND of position solved and timing synchronized.
// - idle mode holds the output inactive.
// - reset: channel 0 per-second, 1 per-minute, 200 ms high; channel 2 telegram.
// - telegram marks carry local time, daylight-saving and leap second announcements.
// - a whole telegram is sent every minute.
// - each telegram mark starts at a new second.
// - zero is a 100 ms mark, one a 200 ms mark.
// - date, time, parity and status ride in seconds 16 to 58.
// - second 59 carries no mark.
// - telegram output runs right after power-up.
// - pulse outputs wait for first sync unless a per-channel option enables them.
// - per-channel polarity and width of 10 ms to 10 s in 10 ms steps.
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ppg_pulse_gen #(
  parameter int unsigned CYC_TICK = ppg_pkg::CYC_TICK
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic sec_tick,
  input wire logic [5:0] loc_sec,
  input wire logic [5:0] loc_min,
  input wire logic [4:0] loc_hour,
  input wire logic [4:0] loc_mday,
  input wire logic [2:0] loc_wday,
  input wire logic [3:0] loc_month,
  input wire logic [6:0] loc_year,
  input wire logic loc_dst,
  input wire logic dst_announce,
  input wire logic leap_announce,
  input wire logic pos_solved,
  input wire logic time_synced,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic pulse_channel_0,
  output logic pulse_channel_1,
  output logic pulse_channel_2
);

  localparam int NCH = ppg_pkg::NCH;
  localparam int NPAIR = ppg_pkg::NPAIR;
  localparam int TW = (CYC_TICK > 2) ? $clog2(CYC_TICK) : 1;

  if (CYC_TICK < 2) begin : g_bad_tick
    $error("CYC_TICK must be at least 2");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // time of day and telegram bits

  function automatic logic [7:0] bcd8(input logic [6:0] v);
    bcd8 = {4'(v / 7'h0a), 4'(v % 7'h0a)};
  endfunction : bcd8

  logic [16:0] sod;
  logic [7:0] b_min;
  logic [7:0] b_hour;
  logic [7:0] b_day;
  logic [7:0] b_mon;
  logic [7:0] b_year;
  logic [58:0] tel;
  logic tel_bit;
  logic both_ok;

  always_comb begin
    sod = 17'(loc_hour) * ppg_pkg::SEC_PER_HOUR + 17'(loc_min) * ppg_pkg::SEC_PER_MIN
          + 17'(loc_sec);
    both_ok = pos_solved & time_synced;
    b_min = bcd8(7'(loc_min));
    b_hour = bcd8(7'(loc_hour));
    b_day = bcd8(7'(loc_mday));
    b_mon = bcd8(7'(loc_month));
    b_year = bcd8(loc_year);
    tel = '0;
    tel[16] = dst_announce;
    tel[17] = loc_dst;
    tel[18] = !loc_dst;
    tel[19] = leap_announce;
    tel[20] = 1'b1;
    tel[27:21] = b_min[6:0];
    tel[28] = ^b_min[6:0];
    tel[34:29] = b_hour[5:0];
    tel[35] = ^b_hour[5:0];
    tel[41:36] = b_day[5:0];
    tel[44:42] = loc_wday;
    tel[49:45] = b_mon[4:0];
    tel[57:50] = b_year;
    tel[58] = ^tel[57:36];
    tel_bit = (loc_sec < ppg_pkg::SEC_LAST) ? tel[loc_sec] : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // 10 ms tick restarted on every second, sync latch, 8 s relock frame

  logic [TW-1:0] tcnt_r, tcnt_nxt;
  logic [2:0] frm_r, frm_nxt;
  logic sync_seen_r, sync_seen_nxt;
  logic tick10;
  logic relock;

  always_comb begin
    tcnt_nxt = tcnt_r + TW'(1);
    frm_nxt = frm_r;
    tick10 = 1'b0;
    sync_seen_nxt = sync_seen_r | time_synced;
    // 1/8 Hz is the slowest period, so relock every eighth second
    relock = sec_tick && (frm_r == 3'h0);
    if (sec_tick) begin
      tcnt_nxt = '0;
      frm_nxt = frm_r + 3'h1;
    end else if (tcnt_r == TW'(CYC_TICK - 1)) begin
      tcnt_nxt = '0;
      tick10 = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tcnt_r <= '0;
      frm_r <= 3'h0;
      sync_seen_r <= 1'b0;
    end else if (clk_en) begin
      tcnt_r <= tcnt_nxt;
      frm_r <= frm_nxt;
      sync_seen_r <= sync_seen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave front end

  logic acc;
  logic wr_go;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;

  always_comb begin
    acc = clk_en & hsel & htrans[1] & hready;
    wr_go = clk_en & wr_pend_r;
    wr_pend_nxt = acc & hwrite & (hsize == ppg_pkg::SIZE_WORD);
    wr_addr_nxt = acc ? haddr : wr_addr_r;
  end

  // the wait state on writes keeps a following read from seeing stale data
  assign hreadyout = clk_en & !wr_pend_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // channel state

  logic [3:0] mode_r [NCH], mode_nxt [NCH];
  logic [3:0] amode_r [NCH], amode_nxt [NCH];
  logic [3:0] chm [NCH];
  logic inv_r [NCH], inv_nxt [NCH];
  logic imm_r [NCH], imm_nxt [NCH];
  logic [9:0] width_r [NCH], width_nxt [NCH];
  logic [16:0] time_r [NCH], time_nxt [NCH];
  logic [16:0] on_r [NCH][NPAIR], on_nxt [NCH][NPAIR];
  logic [16:0] off_r [NCH][NPAIR], off_nxt [NCH][NPAIR];
  logic [31:0] freq_r [NCH], freq_nxt [NCH];
  logic [31:0] phase_r [NCH], phase_nxt [NCH];
  logic [31:0] nco_r [NCH], nco_nxt [NCH];
  logic [9:0] wcnt_r [NCH], wcnt_nxt [NCH];
  logic act_r [NCH], act_nxt [NCH];
  logic pin_r [NCH], pin_nxt [NCH];

  always_comb begin
    logic start;
    logic pulsed;
    logic lvl;
    logic hit;
    logic [9:0] wload;
    logic [15:0] wreq;
    logic [16:0] cyc;
    start = 1'b0;
    pulsed = 1'b0;
    lvl = 1'b0;
    hit = 1'b0;
    wload = ppg_pkg::W_DEF;
    wreq = hwdata[15:0];
    cyc = 17'h00001;
    for (int c = 0; c < NCH; c++) begin
      mode_nxt[c] = mode_r[c];
      inv_nxt[c] = inv_r[c];
      imm_nxt[c] = imm_r[c];
      width_nxt[c] = width_r[c];
      time_nxt[c] = time_r[c];
      freq_nxt[c] = freq_r[c];
      phase_nxt[c] = phase_r[c];
      for (int p = 0; p < NPAIR; p++) begin
        on_nxt[c][p] = on_r[c][p];
        off_nxt[c][p] = off_r[c][p];
      end
      if (wr_go && wr_addr_r[7:6] == 2'(c)) begin
        case (wr_addr_r[5:0])
          ppg_pkg::OFF_CTRL: begin
            mode_nxt[c] = hwdata[3:0];
            inv_nxt[c] = hwdata[ppg_pkg::CTRL_INV];
            imm_nxt[c] = hwdata[ppg_pkg::CTRL_IMM];
          end
          ppg_pkg::OFF_WIDTH: begin
            if (wreq == 16'h0000) begin
              width_nxt[c] = ppg_pkg::W_MIN;
            end else if (wreq > 16'(ppg_pkg::W_MAX)) begin
              width_nxt[c] = ppg_pkg::W_MAX;
            end else begin
              width_nxt[c] = wreq[9:0];
            end
          end
          ppg_pkg::OFF_TIME: time_nxt[c] = hwdata[16:0];
          ppg_pkg::OFF_FREQ: freq_nxt[c] = hwdata;
          ppg_pkg::OFF_PHASE: phase_nxt[c] = hwdata;
          default: begin
            for (int p = 0; p < NPAIR; p++) begin
              if (wr_addr_r[5:0] == 6'(ppg_pkg::OFF_ON0 + ppg_pkg::PAIR_STRIDE * p)) begin
                on_nxt[c][p] = hwdata[16:0];
              end
              if (wr_addr_r[5:0] == 6'(ppg_pkg::OFF_OFF0 + ppg_pkg::PAIR_STRIDE * p)) begin
                off_nxt[c][p] = hwdata[16:0];
              end
            end
          end
        endcase
      end

      // the new mode starts only with a fresh second, so no pulse shorter than a second is cut short
      chm[c] = sec_tick ? mode_r[c] : amode_r[c];
      amode_nxt[c] = chm[c];
      start = 1'b0;
      pulsed = 1'b0;
      lvl = act_r[c];
      wload = width_r[c];
      cyc = (time_r[c] == 17'h00000) ? 17'h00001 : time_r[c];
      hit = 1'b0;
      for (int p = 0; p < NPAIR; p++) begin
        if (on_r[c][p] < off_r[c][p]) begin
          hit = hit | (sod >= on_r[c][p] && sod < off_r[c][p]);
        end else if (on_r[c][p] > off_r[c][p]) begin
          hit = hit | (sod >= on_r[c][p] || sod < off_r[c][p]);
        end
      end
      nco_nxt[c] = nco_r[c] + freq_r[c];
      if (relock) begin
        nco_nxt[c] = (freq_r[c] < ppg_pkg::SYN_PHASE_LIM) ? phase_r[c] : 32'h00000000;
      end
      case (chm[c])
        ppg_pkg::MODE_TIMER: lvl = sec_tick ? hit : act_r[c];
        ppg_pkg::MODE_SHOT: begin
          pulsed = 1'b1;
          start = sec_tick && (sod == time_r[c]);
        end
        ppg_pkg::MODE_CYCLIC: begin
          pulsed = 1'b1;
          start = sec_tick && ((sod % cyc) == 17'h00000);
        end
        ppg_pkg::MODE_PER_SEC: begin
          pulsed = 1'b1;
          start = sec_tick;
        end
        ppg_pkg::MODE_PER_MIN: begin
          pulsed = 1'b1;
          start = sec_tick && (loc_sec == 6'h00);
        end
        ppg_pkg::MODE_PER_HOUR: begin
          pulsed = 1'b1;
          start = sec_tick && (loc_sec == 6'h00) && (loc_min == 6'h00);
        end
        ppg_pkg::MODE_SYNTH: lvl = nco_nxt[c][31];
        ppg_pkg::MODE_POS_OK: lvl = pos_solved;
        ppg_pkg::MODE_TIME_SYNC: lvl = time_synced;
        ppg_pkg::MODE_ALL_SYNC: lvl = both_ok;
        ppg_pkg::MODE_TELEGRAM: begin
          pulsed = 1'b1;
          start = sec_tick && (loc_sec < ppg_pkg::SEC_LAST);
          wload = tel_bit ? ppg_pkg::W_ONE : ppg_pkg::W_ZERO;
        end
        default: lvl = 1'b0;
      endcase
      wcnt_nxt[c] = 10'h000;
      if (pulsed) begin
        if (start) begin
          wcnt_nxt[c] = wload;
        end else if (tick10 && wcnt_r[c] != 10'h000) begin
          wcnt_nxt[c] = wcnt_r[c] - 10'h001;
        end else begin
          wcnt_nxt[c] = wcnt_r[c];
        end
        lvl = (wcnt_nxt[c] != 10'h000);
      end
      // telegram marks run from power-up, the rest wait for the first sync unless imm_r is set
      act_nxt[c] = lvl & (sync_seen_r | imm_r[c] | (chm[c] == 4'(ppg_pkg::MODE_TELEGRAM)));
      pin_nxt[c] = act_nxt[c] ^ inv_nxt[c];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      for (int c = 0; c < NCH; c++) begin
        mode_r[c] <= ppg_pkg::RST_MODE[c];
        amode_r[c] <= ppg_pkg::RST_MODE[c];
        inv_r[c] <= 1'b0;
        imm_r[c] <= 1'b0;
        width_r[c] <= ppg_pkg::W_DEF;
        time_r[c] <= ppg_pkg::RST_TIME;
        freq_r[c] <= 32'h00000000;
        phase_r[c] <= 32'h00000000;
        nco_r[c] <= 32'h00000000;
        wcnt_r[c] <= 10'h000;
        act_r[c] <= 1'b0;
        pin_r[c] <= 1'b0;
        for (int p = 0; p < NPAIR; p++) begin
          on_r[c][p] <= 17'h00000;
          off_r[c][p] <= 17'h00000;
        end
      end
    end else if (clk_en) begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      mode_r <= mode_nxt;
      amode_r <= amode_nxt;
      inv_r <= inv_nxt;
      imm_r <= imm_nxt;
      width_r <= width_nxt;
      time_r <= time_nxt;
      freq_r <= freq_nxt;
      phase_r <= phase_nxt;
      nco_r <= nco_nxt;
      wcnt_r <= wcnt_nxt;
      act_r <= act_nxt;
      pin_r <= pin_nxt;
      on_r <= on_nxt;
      off_r <= off_nxt;
    end
  end

  assign pulse_channel_0 = pin_r[0];
  assign pulse_channel_1 = pin_r[1];
  assign pulse_channel_2 = pin_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // read mux, loaded in the address phase

  always_comb begin
    hrdata_nxt = hrdata_r;
    if (acc && !hwrite) begin
      hrdata_nxt = 32'h00000000;
      if (haddr[7:6] == ppg_pkg::STATUS_SLOT) begin
        if (haddr[5:0] == ppg_pkg::OFF_STATUS) begin
          hrdata_nxt = {26'h0000000, sync_seen_r, time_synced, pos_solved,
                        pin_r[2], pin_r[1], pin_r[0]};
        end
      end else begin
        for (int c = 0; c < NCH; c++) begin
          if (haddr[7:6] == 2'(c)) begin
            case (haddr[5:0])
              ppg_pkg::OFF_CTRL: hrdata_nxt = {26'h0000000, imm_r[c], inv_r[c], mode_r[c]};
              ppg_pkg::OFF_WIDTH: hrdata_nxt = 32'(width_r[c]);
              ppg_pkg::OFF_TIME: hrdata_nxt = 32'(time_r[c]);
              ppg_pkg::OFF_FREQ: hrdata_nxt = freq_r[c];
              ppg_pkg::OFF_PHASE: hrdata_nxt = phase_r[c];
              default: begin
                for (int p = 0; p < NPAIR; p++) begin
                  if (haddr[5:0] == 6'(ppg_pkg::OFF_ON0 + ppg_pkg::PAIR_STRIDE * p)) begin
                    hrdata_nxt = 32'(on_r[c][p]);
                  end
                  if (haddr[5:0] == 6'(ppg_pkg::OFF_OFF0 + ppg_pkg::PAIR_STRIDE * p)) begin
                    hrdata_nxt = 32'(off_r[c][p]);
                  end
                end
              end
            endcase
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    sequence s_rise;
      !act_r[g] ##1 act_r[g];
    endsequence
    property p_idle;
      clk_en && chm[g] == 4'(ppg_pkg::MODE_IDLE) |=> !act_r[g];
    endproperty
    a_idle: assert property (p_idle) else $error("idle channel active");
    property p_pps;
      clk_en && sec_tick && mode_r[g] == 4'(ppg_pkg::MODE_PER_SEC) && sync_seen_r
        |=> act_r[g] && wcnt_r[g] == $past(width_r[g]);
    endproperty
    a_pps: assert property (p_pps) else $error("second pulse missing");
    property p_all;
      clk_en && chm[g] == 4'(ppg_pkg::MODE_ALL_SYNC) && sync_seen_r |=> act_r[g] == $past(both_ok);
    endproperty
    a_all: assert property (p_all) else $error("combined status wrong");
    property p_sync;
      clk_en && chm[g] == 4'(ppg_pkg::MODE_TIME_SYNC) && (sync_seen_r || imm_r[g])
        |=> act_r[g] == $past(time_synced);
    endproperty
    a_sync: assert property (p_sync) else $error("sync status wrong");
    property p_gap;
      clk_en && sec_tick && mode_r[g] == 4'(ppg_pkg::MODE_TELEGRAM) && loc_sec == ppg_pkg::SEC_LAST
        |=> !act_r[g];
    endproperty
    a_gap: assert property (p_gap) else $error("mark in last second");
    property p_mark;
      clk_en && sec_tick && mode_r[g] == 4'(ppg_pkg::MODE_TELEGRAM) && loc_sec < ppg_pkg::SEC_LAST
        |=> act_r[g] && wcnt_r[g] == ($past(tel_bit) ? ppg_pkg::W_ONE : ppg_pkg::W_ZERO);
    endproperty
    a_mark: assert property (p_mark) else $error("mark width wrong");
    property p_edge;
      s_rise |-> $past(sec_tick) || amode_r[g] != 4'(ppg_pkg::MODE_TELEGRAM);
    endproperty
    a_edge: assert property (p_edge) else $error("mark off the second");
    property p_hold;
      !(clk_en && sec_tick) |=> $stable(amode_r[g]);
    endproperty
    a_hold: assert property (p_hold) else $error("mode changed mid second");
    property p_gate;
      clk_en && !sync_seen_r && !imm_r[g] && chm[g] != 4'(ppg_pkg::MODE_TELEGRAM) |=> !act_r[g];
    endproperty
    a_gate: assert property (p_gate) else $error("output before sync");
    property p_wmax;
      wcnt_r[g] <= ppg_pkg::W_MAX && width_r[g] >= ppg_pkg::W_MIN && width_r[g] <= ppg_pkg::W_MAX;
    endproperty
    a_wmax: assert property (p_wmax) else $error("width out of range");
  end

endmodule : ppg_pulse_gen

`default_nettype wire

//--- ppg_ttl_load.sv
// Purpose: ttl load that measures each active-high run on one pulse pin
// Assumes: pin sampled on the rising clock edge
// Notes:   a run is queued when it ends, so a cut-short pulse still shows up
`timescale 1ns/1ps
`default_nettype none

module ppg_ttl_load (
  input wire logic clk,
  input wire logic pin
);
  int run = 0;
  int widths[$];

  ////////////////////////////////////////////////////////////////////////////
  // an unknown pin never counts as high
  always @(posedge clk) begin
    if (pin === 1'b1) begin
      run++;
    end else if (run != 0) begin
      widths.push_back(run);
      run = 0;
    end
  end
endmodule : ppg_ttl_load

`default_nettype wire

//--- programmable_pulse_outputs_tb_top.sv
// Purpose: self-checking bench of the three-channel pulse generator
// Assumes: tick shortened to 10 clocks, so one second is 1000 clocks
// Notes:   loads measure every pulse; a model gives the expected lengths
`timescale 1ns/1ps
`default_nettype none

`define chk(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end

module programmable_pulse_outputs_tb_top;
  localparam int CT = 10;
  logic clk, reset_n, clk_en, sec_tick, loc_dst, dst_announce, leap_announce;
  logic pos_solved, time_synced, hsel, hwrite, hready, hreadyout, hresp;
  logic [5:0] loc_sec, loc_min;
  logic [4:0] loc_hour, loc_mday;
  logic [2:0] loc_wday, hsize;
  wire logic [2:0] pins;
  logic [3:0] loc_month;
  logic [6:0] loc_year;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  int fails, comparisons, mn, w, wd;

  // single slave: its ready is the bus ready
  assign hready = hreadyout;

  ppg_pulse_gen #(.CYC_TICK(CT)) i_dut (.clk, .reset_n, .clk_en, .sec_tick, .loc_sec,
    .loc_min, .loc_hour, .loc_mday, .loc_wday, .loc_month, .loc_year, .loc_dst,
    .dst_announce, .leap_announce, .pos_solved, .time_synced, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .pulse_channel_0(pins[0]), .pulse_channel_1(pins[1]), .pulse_channel_2(pins[2]));
  ppg_ttl_load i_l0 (.clk(clk), .pin(pins[0]));
  ppg_ttl_load i_l1 (.clk(clk), .pin(pins[1]));
  ppg_ttl_load i_l2 (.clk(clk), .pin(pins[2]));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // address phase then data phase, each held until ready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
        fails++;
        stop_test();
      end
      if (ph == 0) begin
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    rd = hrdata;
  endtask : bus

  task automatic second(input int s, input int n = 999);
    loc_sec <= 6'(s);
    sec_tick <= 1'b1;
    @(posedge clk);
    sec_tick <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : second

  // first run seen on a channel, in clocks; the rest is dropped
  task automatic got(input int ch);
    int q[$];
    case (ch)
      0: q = i_l0.widths;
      1: q = i_l1.widths;
      default: q = i_l2.widths;
    endcase
    w = q.size() > 0 ? q[0] : 0;
    case (ch)
      0: i_l0.widths.delete();
      1: i_l1.widths.delete();
      default: i_l2.widths.delete();
    endcase
  endtask : got

  // telegram mark length in ticks for second s
  function automatic int tg(input int s);
    int m;
    int b;
    m = mn / 10 * 16 + mn % 10;
    case (s)
      16: b = dst_announce;
      17: b = loc_dst;
      18: b = !loc_dst;
      19: b = leap_announce;
      20: b = 1;
      28: b = ^m[6:0];
      default: b = (s > 20 && s < 28) ? (m >> (s - 21)) & 1 : 0;
    endcase
    return (s == 59) ? 0 : 10 + 10 * b;
  endfunction : tg

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    void'($urandom(32'h9508fd75));
    fails = 0;
    comparisons = 0;
    mn = $urandom_range(59);
    {reset_n, sec_tick, pos_solved, time_synced, hsel, hwrite} = '0;
    {htrans, hsize, haddr, hwdata, loc_sec} = '0;
    clk_en = 1'b1;
    loc_min = 6'(mn);
    loc_hour = 5'($urandom_range(23));
    loc_mday = 5'($urandom_range(31, 1));
    loc_wday = 3'($urandom_range(7, 1));
    loc_month = 4'($urandom_range(12, 1));
    loc_year = 7'($urandom_range(99));
    {loc_dst, dst_announce, leap_announce} = 3'($urandom);
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int c = 0; c < 3; c++) begin
      bus(0, 8'(c * 64), 0);
      `chk(rd, c == 0 ? 32'h4 : c == 1 ? 32'h5 : 32'hc)
      bus(0, 8'(c * 64 + 4), 0);
      `chk(rd, 32'h14)
    end
    bus(0, 8'hfc, 0);
    `chk(rd, 32'h0)
    `chk(hresp, 1'b0)
    $display("test defaults done");
    // no sync yet: only the telegram channel may speak
    for (int i = 0; i < 30; i++) begin
      second(i < 29 ? i : 59);
      got(2);
      `chk(w, tg(i < 29 ? i : 59) * CT)
      got(0);
      `chk(w, 0)
    end
    $display("test telegram done");
    time_synced <= 1'b1;
    repeat (2) @(posedge clk);
    second(0);
    got(0);
    `chk(w, 20 * CT)
    got(1);
    `chk(w, 20 * CT)
    bus(1, 8'h40, 32'h6);
    loc_min <= 6'd7;
    second(0);
    got(1);
    `chk(w, 0)
    loc_min <= 6'd0;
    second(0);
    got(1);
    `chk(w, 20 * CT)
    $display("test sync pulses done");
    wd = $urandom_range(40, 1);
    bus(1, 8'h04, 32'(wd));
    bus(0, 8'h04, 0);
    `chk(rd, 32'(wd))
    got(0);
    second(2);
    got(0);
    `chk(w, wd * CT)
    bus(1, 8'h04, 32'h0);
    bus(0, 8'h04, 0);
    `chk(rd, 32'h1)
    bus(1, 8'h04, 32'h3e9);
    bus(0, 8'h04, 0);
    `chk(rd, 32'h3e8)
    bus(1, 8'h04, 32'h14);
    // idle written while a pulse is high must not cut it
    second(3, 5);
    bus(1, 8'h00, 32'h0);
    repeat (400) @(posedge clk);
    got(0);
    `chk(w, 20 * CT)
    second(4);
    got(0);
    `chk(w, 0)
    $display("test width and idle done");
    bus(1, 8'h00, 32'h9);
    bus(1, 8'h40, 32'ha);
    bus(1, 8'h80, 32'hb);
    second(5, 5);
    for (int i = 0; i < 8; i++) begin
      pos_solved <= 1'($urandom_range(1));
      time_synced <= 1'($urandom_range(1));
      repeat (3) @(posedge clk);
      `chk(pins, {pos_solved & time_synced, time_synced, pos_solved})
    end
    bus(0, 8'hc0, 0);
    `chk(rd, {26'h0000000, 1'b1, time_synced, pos_solved, pos_solved & time_synced, time_synced, pos_solved})
    bus(1, 8'h40, 32'h14);
    second(6, 5);
    `chk(pins[1], 1'b0)
    repeat (300) @(posedge clk);
    `chk(pins[1], 1'b1)
    $display("test status and polarity done");
    reset_n <= 1'b0;
    time_synced <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(1, 8'h00, 32'h24);
    got(0);
    got(1);
    second(0);
    got(0);
    `chk(w, 20 * CT)
    got(1);
    `chk(w, 0)
    $display("test early enable done");
    time_synced <= 1'b1;
    {loc_min, loc_hour} <= '0;
    bus(1, 8'h48, 32'h3);
    bus(1, 8'h40, 32'h3);
    bus(1, 8'h88, 32'hc);
    bus(1, 8'h80, 32'h2);
    bus(1, 8'h0c, 32'hb);
    bus(1, 8'h10, 32'hd);
    bus(1, 8'h00, 32'h1);
    for (int c = 0; c < 3; c++) got(c);
    for (int s = 9; s < 14; s++) begin
      second(s);
      got(1);
      `chk(w, s % 3 == 0 ? 20 * CT : 0)
      got(2);
      `chk(w, s == 12 ? 20 * CT : 0)
    end
    got(0);
    `chk(w, 2000)
    $display("test timer cyclic shot done");
    // increment of 2^27 per clock: msb toggles every 16 clocks
    bus(1, 8'h24, 32'h08000000);
    bus(1, 8'h00, 32'h7);
    second(14, 100);
    got(0);
    repeat (100) @(posedge clk);
    got(0);
    `chk(w, 16)
    $display("test synthesizer done");
    stop_test();
  end
endmodule : programmable_pulse_outputs_tb_top

`default_nettype wire
